// File: pom_pkg.sv
// Constants, types and register map of the programmable output macrocell array
// Operation
// - Registered cells share clock and enable pins
// - Registered mode: each cell registered or I/O
// - Registered sums eight terms, I/O seven
// - Complex mode: output-only or bidirectional, six max
// - Complex mode: outer cells have no input
// - Complex: seven terms plus one enable term
// - Complex/simple: clock and enable pins are data
// - Simple: dedicated input or always-on output
// - Simple: eight terms, per-cell polarity
// - Simple: centre cells only dedicated outputs
// - Simple direction zero: output with feedback
// - Polarity zero active low, one active high
// - Simple direction one: dedicated input
// - Simple: centre cells fixed outputs, no feedback
// - Sixty-four signature bits as eight bytes
// - Two global bits select mode for all
// - Registered: clock and enable pins not data
package pom_pkg;

	// ***********************************************************
	// Sizes
	// ***********************************************************
	localparam int NCELL = 8;
	localparam int NTERM = 8;
	localparam int NARRAY = 16;
	localparam int NFUSE_WORD = 64;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// ***********************************************************
	// Register map (byte addresses)
	// ***********************************************************
	localparam logic [11:0] ADDR_ARCH = 12'h000;
	localparam logic [11:0] ADDR_POL = 12'h004;
	localparam logic [11:0] ADDR_DIR = 12'h008;
	localparam logic [11:0] ADDR_COMMIT = 12'h00c;
	localparam logic [11:0] ADDR_PINS = 12'h010;
	localparam logic [11:0] ADDR_TOFF_LO = 12'h018;
	localparam logic [11:0] ADDR_TOFF_HI = 12'h01c;
	localparam logic [11:0] ADDR_SIG_LO = 12'h020;
	localparam logic [11:0] ADDR_SIG_HI = 12'h024;
	localparam logic [3:0] FUSE_PAGE = 4'h1;

	// Field positions
	localparam int ARCH_SEL_BIT = 0;
	localparam int ARCH_CFG0_BIT = 1;
	localparam int STAT_MODE_LSB = 0;
	localparam int STAT_POL_LSB = 8;
	localparam int STAT_DIR_LSB = 16;

	// Reset values: erased fuses connect every literal, so every term is low
	localparam logic [31:0] FUSE_RESET = 32'hffffffff;
	localparam logic [7:0] POL_RESET = 8'h00;
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [63:0] SIG_RESET = 64'h0000000000000000;
	localparam logic [63:0] TOFF_RESET = 64'h0000000000000000;

	localparam logic [7:0] CENTRE_CELLS = 8'h18;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ***********************************************************
	// Types
	// ***********************************************************
	typedef enum logic [1:0] {
		POM_MODE_REG = 2'b00,
		POM_MODE_CPLX = 2'b01,
		POM_MODE_SIMPLE = 2'b10
	} pom_mode_e;

	typedef struct packed {
		logic clk_pin;
		logic oe_n;
		logic [7:0] din;
	} pom_pins_in_s;

	typedef struct packed {
		logic global_register_select;
		logic global_config_bit_zero;
		logic [7:0] pol;
		logic [7:0] cell_direction_bit;
	} pom_cfg_s;

	typedef struct packed {
		logic aw_full;
		logic w_full;
		logic [11:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} pom_axil_st_s;

	typedef struct packed {
		pom_cfg_s stage;
		pom_cfg_s act;
		logic [63:0] term_disable_fuses;
		logic [63:0] user_signature_fuses;
		logic [63:0][31:0] fuse;
		logic clk_prev;
		logic [7:0] reg_q;
		logic [7:0] pin_out;
		logic [7:0] pin_oe;
	} pom_main_st_s;

endpackage

// File: pom_axil_slave.sv
// AXI4-Lite slave front end: one write and one read in flight
`timescale 1ns/10ps
module pom_axil_slave (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [pom_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [pom_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [pom_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [pom_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic wr_en,
	output logic [pom_pkg::ADDR_W-1:0] wr_addr,
	output logic [pom_pkg::DATA_W-1:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_ok,
	output logic rd_en,
	output logic [pom_pkg::ADDR_W-1:0] rd_addr,
	input wire logic [pom_pkg::DATA_W-1:0] rd_data,
	input wire logic rd_ok
);
	import pom_pkg::*;

	pom_axil_st_s st;
	pom_axil_st_s next_st;

	// Address and data are held until both are in, in either order
	assign awready = !st.aw_full && !st.bvalid;
	assign wready = !st.w_full && !st.bvalid;
	assign arready = !st.rvalid;
	assign wr_en = st.aw_full && st.w_full && !st.bvalid;
	assign wr_addr = st.aw_addr;
	assign wr_data = st.w_data;
	assign wr_strb = st.w_strb;
	assign rd_en = arvalid && arready;
	assign rd_addr = araddr;
	assign bvalid = st.bvalid;
	assign bresp = st.bresp;
	assign rvalid = st.rvalid;
	assign rdata = st.rdata;
	assign rresp = st.rresp;

	always_comb begin
		next_st = st;
		if (awvalid && awready) begin
			next_st.aw_full = 1'b1;
			next_st.aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			next_st.w_full = 1'b1;
			next_st.w_data = wdata;
			next_st.w_strb = wstrb;
		end
		if (st.bvalid && bready) begin
			next_st.bvalid = 1'b0;
		end
		if (wr_en) begin
			next_st.aw_full = 1'b0;
			next_st.w_full = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		if (st.rvalid && rready) begin
			next_st.rvalid = 1'b0;
		end
		if (rd_en) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = rd_data;
			next_st.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule

// File: pom_term_array.sv
// Product terms of one macrocell: AND of the connected literals
`timescale 1ns/10ps
module pom_term_array (
	input wire logic [pom_pkg::NARRAY-1:0] array_in,
	input wire logic [pom_pkg::NTERM-1:0][31:0] fuse,
	input wire logic [pom_pkg::NTERM-1:0] term_off,
	output logic [pom_pkg::NTERM-1:0] terms
);
	import pom_pkg::*;

	always_comb begin
		logic [31:0] lit;
		lit = '0;
		// Even column is the true literal, odd the complement
		for (int k = 0; k < NARRAY; k++) begin
			lit[2*k] = array_in[k];
			lit[2*k+1] = ~array_in[k];
		end
		for (int t = 0; t < NTERM; t++) begin
			terms[t] = !term_off[t] && (&(lit | ~fuse[t]));
		end
	end

endmodule

// File: pom_macrocell_array.sv
// Eight output macrocells with register map, mode logic and signature
`timescale 1ns/10ps
module pom_macrocell_array (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [pom_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [pom_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [pom_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [pom_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire pom_pkg::pom_pins_in_s pins_in,
	input wire logic [pom_pkg::NCELL-1:0] mc_pin_in,
	output logic [pom_pkg::NCELL-1:0] mc_pin_out,
	output logic [pom_pkg::NCELL-1:0] mc_pin_oe
);
	import pom_pkg::*;

	// ***********************************************************
	// Functions
	// ***********************************************************
	function automatic pom_mode_e decode_mode(input logic sel, input logic cfg0);
		if (sel && !cfg0) begin
			return POM_MODE_SIMPLE;
		end else if (sel) begin
			return POM_MODE_CPLX;
		end
		return POM_MODE_REG;
	endfunction

	function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = data[8*b +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic reg_hit(input logic [11:0] addr);
		logic hit;
		hit = (addr[1:0] == 2'b00) && (addr[11:8] == FUSE_PAGE);
		case (addr)
			ADDR_ARCH, ADDR_POL, ADDR_DIR, ADDR_COMMIT, ADDR_PINS, ADDR_TOFF_LO, ADDR_TOFF_HI,
			ADDR_SIG_LO, ADDR_SIG_HI: begin
				hit = 1'b1;
			end
			default: begin
			end
		endcase
		return hit;
	endfunction

	// ***********************************************************
	// Bus front end
	// ***********************************************************
	pom_main_st_s st;
	pom_main_st_s next_st;
	logic wr_en;
	logic [11:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_ok;
	logic rd_en;
	logic [11:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_ok;

	pom_axil_slave u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_ok(wr_ok),
		.rd_en(rd_en),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_ok(rd_ok)
	);

	// ***********************************************************
	// Array inputs and product terms
	// ***********************************************************
	pom_mode_e mode;
	logic [NARRAY-1:0] array_in;
	logic [NCELL-1:0][NTERM-1:0] terms;
	logic [NCELL-1:0] cell_val;
	logic [NCELL-1:0] cell_oe;
	logic [NCELL-1:0] reg_d;
	logic [NCELL-1:0] dir;
	logic [NCELL-1:0] pol;
	logic clk_rise;

	assign mode = decode_mode(st.act.global_register_select,
		st.act.global_config_bit_zero);
	assign dir = st.act.cell_direction_bit;
	assign pol = st.act.pol;
	assign clk_rise = pins_in.clk_pin && !st.clk_prev;

	always_comb begin
		array_in[7:0] = pins_in.din;
		case (mode)
			POM_MODE_REG: begin
				// Clock and enable pins never reach the array
				for (int i = 0; i < NCELL; i++) begin
					array_in[8+i] = dir[i] ? mc_pin_in[i] : st.reg_q[i];
				end
			end
			POM_MODE_CPLX: begin
				array_in[15:8] = mc_pin_in;
				array_in[8] = pins_in.oe_n;
				array_in[15] = pins_in.clk_pin;
			end
			POM_MODE_SIMPLE: begin
				array_in[15:8] = mc_pin_in;
				// Centre feedback slots carry the two spare pins instead
				array_in[11] = pins_in.clk_pin;
				array_in[12] = pins_in.oe_n;
			end
			default: begin
				array_in[15:8] = 8'h00;
			end
		endcase
	end

	for (genvar c = 0; c < NCELL; c++) begin : g_cell
		pom_term_array u_terms (
			.array_in(array_in),
			.fuse(st.fuse[c*NTERM +: NTERM]),
			.term_off(st.term_disable_fuses[c*NTERM +: NTERM]),
			.terms(terms[c])
		);
	end

	// ***********************************************************
	// Macrocell output logic
	// ***********************************************************
	always_comb begin
		for (int i = 0; i < NCELL; i++) begin
			reg_d[i] = pol[i] ~^ (|terms[i]);
			cell_val[i] = 1'b0;
			cell_oe[i] = 1'b0;
			case (mode)
				POM_MODE_REG: begin
					if (dir[i]) begin
						cell_val[i] = pol[i] ~^ (|terms[i][7:1]);
						cell_oe[i] = terms[i][0];
					end else begin
						cell_val[i] = st.reg_q[i];
						cell_oe[i] = !pins_in.oe_n;
					end
				end
				POM_MODE_CPLX: begin
					cell_val[i] = pol[i] ~^ (|terms[i][7:1]);
					cell_oe[i] = terms[i][0];
				end
				POM_MODE_SIMPLE: begin
					cell_val[i] = pol[i] ~^ (|terms[i]);
					cell_oe[i] = CENTRE_CELLS[i] || !dir[i];
				end
				default: begin
				end
			endcase
		end
	end

	// ***********************************************************
	// Register file and state update
	// ***********************************************************
	always_comb begin
		logic [5:0] widx;
		logic [5:0] ridx;
		logic [31:0] word;
		widx = wr_addr[7:2];
		ridx = rd_addr[7:2];
		word = '0;
		next_st = st;
		next_st.clk_prev = pins_in.clk_pin;
		if (mode == POM_MODE_REG && clk_rise) begin
			for (int i = 0; i < NCELL; i++) begin
				if (!dir[i]) begin
					next_st.reg_q[i] = reg_d[i];
				end
			end
		end
		next_st.pin_out = cell_val;
		next_st.pin_oe = cell_oe;
		wr_ok = reg_hit(wr_addr);
		if (wr_en) begin
			case (wr_addr)
				ADDR_ARCH: begin
					word = apply_strb({30'h0, st.stage.global_config_bit_zero,
						st.stage.global_register_select}, wr_data, wr_strb);
					next_st.stage.global_register_select = word[ARCH_SEL_BIT];
					next_st.stage.global_config_bit_zero = word[ARCH_CFG0_BIT];
				end
				ADDR_POL: begin
					word = apply_strb({24'h0, st.stage.pol}, wr_data, wr_strb);
					next_st.stage.pol = word[7:0];
				end
				ADDR_DIR: begin
					word = apply_strb({24'h0, st.stage.cell_direction_bit}, wr_data, wr_strb);
					next_st.stage.cell_direction_bit = word[7:0];
				end
				ADDR_COMMIT: begin
					next_st.act = st.stage;
				end
				ADDR_TOFF_LO: begin
					next_st.term_disable_fuses[31:0] =
						apply_strb(st.term_disable_fuses[31:0], wr_data, wr_strb);
				end
				ADDR_TOFF_HI: begin
					next_st.term_disable_fuses[63:32] =
						apply_strb(st.term_disable_fuses[63:32], wr_data, wr_strb);
				end
				ADDR_SIG_LO: begin
					next_st.user_signature_fuses[31:0] =
						apply_strb(st.user_signature_fuses[31:0], wr_data, wr_strb);
				end
				ADDR_SIG_HI: begin
					next_st.user_signature_fuses[63:32] =
						apply_strb(st.user_signature_fuses[63:32], wr_data, wr_strb);
				end
				default: begin
					// Only the fuse page may land here; the pins status word is read only
					if (wr_ok && wr_addr[11:8] == FUSE_PAGE) begin
						next_st.fuse[widx] = apply_strb(st.fuse[widx], wr_data, wr_strb);
					end
				end
			endcase
		end
		// Read data; pins status is read only and writes to it are dropped
		rd_ok = reg_hit(rd_addr);
		rd_data = '0;
		case (rd_addr)
			ADDR_ARCH: begin
				rd_data[ARCH_SEL_BIT] = st.stage.global_register_select;
				rd_data[ARCH_CFG0_BIT] = st.stage.global_config_bit_zero;
			end
			ADDR_POL: rd_data[7:0] = st.stage.pol;
			ADDR_DIR: rd_data[7:0] = st.stage.cell_direction_bit;
			ADDR_COMMIT: begin
				rd_data[STAT_MODE_LSB +: 2] = mode;
				rd_data[STAT_POL_LSB +: 8] = st.act.pol;
				rd_data[STAT_DIR_LSB +: 8] = st.act.cell_direction_bit;
			end
			ADDR_PINS: rd_data = {mc_pin_in, st.reg_q, st.pin_oe, st.pin_out};
			ADDR_TOFF_LO: rd_data = st.term_disable_fuses[31:0];
			ADDR_TOFF_HI: rd_data = st.term_disable_fuses[63:32];
			ADDR_SIG_LO: rd_data = st.user_signature_fuses[31:0];
			ADDR_SIG_HI: rd_data = st.user_signature_fuses[63:32];
			default: begin
				if (rd_ok) begin
					rd_data = st.fuse[ridx];
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st.stage <= {1'b0, 1'b0, POL_RESET, DIR_RESET};
			st.act <= {1'b0, 1'b0, POL_RESET, DIR_RESET};
			st.term_disable_fuses <= TOFF_RESET;
			st.user_signature_fuses <= SIG_RESET;
			st.fuse <= {NFUSE_WORD{FUSE_RESET}};
			st.clk_prev <= 1'b0;
			st.reg_q <= 8'h00;
			st.pin_out <= 8'h00;
			st.pin_oe <= 8'h00;
		end else begin
			st <= next_st;
		end
	end

	assign mc_pin_out = st.pin_out;
	assign mc_pin_oe = st.pin_oe;

	// ***********************************************************
	// Assertions
	// ***********************************************************
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_shared_oe_gate: assert property (
		mode == POM_MODE_REG |=> ((mc_pin_oe ^ {8{!$past(pins_in.oe_n)}}) & ~$past(dir)) == 8'h00)
		else $error("registered cell enable does not follow common enable pin");

	a_reg_clock_hold: assert property (
		!(clk_rise && mode == POM_MODE_REG) |=> $stable(st.reg_q))
		else $error("register changed without a clock pin rising edge");

	a_reg_capture_sum: assert property (
		(clk_rise && mode == POM_MODE_REG) |=>
		((st.reg_q ^ $past(reg_d)) & ~$past(dir)) == 8'h00)
		else $error("registered cell did not capture eight term sum");

	a_io_term_enable: assert property (
		(mode == POM_MODE_CPLX) |=> mc_pin_oe == $past({terms[7][0], terms[6][0], terms[5][0],
		terms[4][0], terms[3][0], terms[2][0], terms[1][0], terms[0][0]}))
		else $error("complex mode enable not from first product term");

	a_outer_no_input: assert property (
		mode == POM_MODE_CPLX |-> array_in[8] == pins_in.oe_n && array_in[15] == pins_in.clk_pin)
		else $error("outer cell feedback slot not given to spare pin");

	a_spare_as_data: assert property (
		mode == POM_MODE_SIMPLE |-> array_in[11] == pins_in.clk_pin && array_in[12] == pins_in.oe_n)
		else $error("spare pins not feeding array in simple mode");

	a_simple_enable: assert property (
		mode == POM_MODE_SIMPLE |=> mc_pin_oe == (~$past(dir) | CENTRE_CELLS))
		else $error("simple mode enable wrong for direction setting");

	a_centre_output: assert property (
		mode == POM_MODE_SIMPLE |=> mc_pin_oe[4:3] == 2'b11)
		else $error("centre cell not a fixed output");

	a_polarity_out: assert property (
		(mode == POM_MODE_SIMPLE) |=> mc_pin_out == ~($past(pol) ^ $past({|terms[7], |terms[6],
		|terms[5], |terms[4], |terms[3], |terms[2], |terms[1], |terms[0]})))
		else $error("simple mode output polarity wrong");

	a_config_frozen: assert property (
		!(wr_en && wr_addr == ADDR_COMMIT) |=> $stable(st.act))
		else $error("active configuration changed without reprogram");

	c_reg_clocked: cover property (mode == POM_MODE_REG && clk_rise ##1 st.reg_q != 8'h00);
	c_cplx_mode: cover property (mode == POM_MODE_CPLX && cell_oe != 8'h00);
	c_simple_mode: cover property (mode == POM_MODE_SIMPLE && dir != 8'h00);
	c_reprogram: cover property (wr_en && wr_addr == ADDR_COMMIT);

endmodule

// File: pom_far_side.sv
// Far-side model: drives shared clock, enable and dedicated inputs, resolves cell pins
`timescale 1ns/10ps
module pom_far_side (
	input wire logic clk_req,
	input wire logic oe_n_req,
	input wire logic [7:0] din_req,
	input wire logic [7:0] ext_req,
	input wire logic [pom_pkg::NCELL-1:0] mc_pin_out,
	input wire logic [pom_pkg::NCELL-1:0] mc_pin_oe,
	output pom_pkg::pom_pins_in_s pins_in,
	output logic [pom_pkg::NCELL-1:0] mc_pin_in
);
	import pom_pkg::*;

	// ***********************************************************
	// Shared pins
	// ***********************************************************
	// Clock pin stands low between pulses; one enable for all registered cells
	assign pins_in = {clk_req, oe_n_req, din_req};

	// ***********************************************************
	// Cell pins
	// ***********************************************************
	// Far side only drives where the cell has let go, so no contention
	always_comb begin
		for (int i = 0; i < NCELL; i++) begin
			mc_pin_in[i] = mc_pin_oe[i] ? mc_pin_out[i] : ext_req[i];
		end
	end
endmodule

// File: programmable_output_macrocell_array_bench.sv
// Self-checking bench for the macrocell array: register bus and pin scenarios
`timescale 1ns/10ps
module programmable_output_macrocell_array_bench;
	import pom_pkg::*;

	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [11:0] araddr = 12'h000;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, d;
	pom_pins_in_s pins_in;
	logic [7:0] mc_pin_in, mc_pin_out, mc_pin_oe;
	logic clk_req = 1'b0;
	logic oe_n_req = 1'b1;
	logic [7:0] din_req = 8'h00;
	logic [7:0] ext_req = 8'h5a;
	int n_fail = 0;
	int n_compared = 0;

	always #2 aclk = ~aclk;

	pom_macrocell_array u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .pins_in(pins_in), .mc_pin_in(mc_pin_in), .mc_pin_out(mc_pin_out),
		.mc_pin_oe(mc_pin_oe));

	pom_far_side u_far (.clk_req(clk_req), .oe_n_req(oe_n_req), .din_req(din_req),
		.ext_req(ext_req), .mc_pin_out(mc_pin_out), .mc_pin_oe(mc_pin_oe),
		.pins_in(pins_in), .mc_pin_in(mc_pin_in));

	// ***********************************************************
	// Tasks
	// ***********************************************************
	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Bus tasks sample at the edge, so registered answers are the pre-edge values
	task automatic axw(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		n = 0;
		rs = 2'b11;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (n < 100) begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				rs = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (n >= 100) n_fail++;
	endtask

	task automatic axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		n = 0;
		rs = 2'b11;
		v = 32'h0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (n < 100) begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				v = rdata;
				rs = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (n >= 100) n_fail++;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		logic [1:0] rs;
		axw(a, v, rs);
		chk("bresp", {30'h0, RESP_OKAY}, {30'h0, rs});
	endtask

	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
		logic [31:0] v;
		logic [1:0] rs;
		axr(a, v, rs);
		chk("rresp", {30'h0, RESP_OKAY}, {30'h0, rs});
		chk(nm, e, v);
	endtask

	// Pin outputs lag their causes by a registered stage
	task automatic settle;
		repeat (3) @(posedge aclk);
	endtask

	task automatic pclk;
		@(posedge aclk);
		clk_req <= 1'b1;
		@(posedge aclk);
		clk_req <= 1'b0;
	endtask

	function automatic logic [11:0] fa(input int c, input int t);
		return 12'h100 + 12'(4 * (c * 8 + t));
	endfunction

	// ***********************************************************
	// Watchdog
	// ***********************************************************
	initial begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		summarize();
	end

	// ***********************************************************
	// Scenarios
	// ***********************************************************
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("oe_reset", 32'h0, {24'h0, mc_pin_oe});
		rdc("status_reset", ADDR_COMMIT, 32'h0);
		rdc("sig_reset", ADDR_SIG_LO, 32'h0);
		axr(12'h0f0, d, r);
		chk("rd_unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
		chk("rd_unmapped_data", 32'h0, d);
		axw(12'h0f4, 32'h1, r);
		chk("wr_unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
		// Status word is read only: the write must not reach fuse word 4
		wr(ADDR_PINS, 32'h0);
		rdc("fuse_kept", fa(0, 4), FUSE_RESET);
		wr(ADDR_SIG_LO, 32'h03020100);
		wr(ADDR_SIG_HI, 32'h07060504);
		rdc("sig_lo", ADDR_SIG_LO, 32'h03020100);
		rdc("sig_hi", ADDR_SIG_HI, 32'h07060504);
		// Term 0 of every cell follows its own dedicated input
		for (int c = 0; c < NCELL; c++) begin
			wr(fa(c, 0), 32'h1 << (2 * c));
		end
		wr(ADDR_ARCH, 32'h1);
		wr(ADDR_POL, 32'h0f);
		wr(ADDR_DIR, 32'h19);
		settle();
		rdc("status_staged", ADDR_COMMIT, 32'h0);
		wr(ADDR_COMMIT, 32'h0);
		rdc("status_simple", ADDR_COMMIT, 32'h00190f02);
		din_req <= 8'ha5;
		settle();
		chk("oe_simple", 32'h0fe, {24'h0, mc_pin_oe});
		chk("out_simple", 32'h054, {24'h0, mc_pin_out & 8'hfe});
		// Cell 6 term 1 takes the inverted feedback of output cell 1
		wr(fa(6, 1), 32'h1 << 19);
		settle();
		chk("out_feedback", 32'h014, {24'h0, mc_pin_out & 8'hfe});
		wr(fa(6, 1), FUSE_RESET);
		// Clock pin becomes an ordinary array input outside registered mode
		wr(fa(5, 1), 32'h1 << 22);
		din_req <= 8'h00;
		clk_req <= 1'b1;
		settle();
		chk("out_clk_data", 32'h0d0, {24'h0, mc_pin_out & 8'hfe});
		clk_req <= 1'b0;
		wr(fa(2, 1), 32'h1 << 16);
		wr(ADDR_ARCH, 32'h3);
		wr(ADDR_COMMIT, 32'h0);
		rdc("status_cplx", ADDR_COMMIT, 32'h00190f01);
		din_req <= 8'h04;
		oe_n_req <= 1'b0;
		settle();
		chk("oe_cplx", 32'h004, {24'h0, mc_pin_oe});
		chk("out_cplx_lo", 32'h0, {31'h0, mc_pin_out[2]});
		oe_n_req <= 1'b1;
		settle();
		chk("out_cplx_hi", 32'h1, {31'h0, mc_pin_out[2]});
		wr(fa(2, 1), FUSE_RESET);
		wr(fa(5, 1), FUSE_RESET);
		wr(ADDR_ARCH, 32'h0);
		wr(ADDR_DIR, 32'h80);
		wr(ADDR_COMMIT, 32'h0);
		rdc("status_reg", ADDR_COMMIT, 32'h00800f00);
		// Cell 7 is I/O: term 0 drives its enable, so din7 high turns it on
		din_req <= 8'hbc;
		oe_n_req <= 1'b0;
		pclk();
		settle();
		chk("oe_reg", 32'h0ff, {24'h0, mc_pin_oe});
		chk("out_reg", 32'h0cc, {24'h0, mc_pin_out});
		rdc("pins_reg", ADDR_PINS, 32'hcc4cffcc);
		din_req <= 8'h83;
		settle();
		chk("out_hold", 32'h0cc, {24'h0, mc_pin_out});
		pclk();
		settle();
		chk("out_reg2", 32'h0f3, {24'h0, mc_pin_out});
		oe_n_req <= 1'b1;
		settle();
		chk("oe_off", 32'h080, {24'h0, mc_pin_oe});
		summarize();
	end
endmodule
